// [common/atq_pkg.sv]
package atq_pkg;

   // ****************************************
   // Register map as word indices; byte address is four times the index
   // ****************************************
   localparam logic [15:0] IDX_TRIG_CTRL = 16'h7034;
   localparam logic [15:0] IDX_FIRST_Q = 16'h7036;
   localparam logic [15:0] IDX_SECOND_Q = 16'h7038;
   localparam logic [15:0] IDX_CONV_CTRL = 16'h7040;
   localparam logic [15:0] IDX_CONV_DATA = 16'h7041;
   localparam logic [15:0] IDX_IRQ_STAT = 16'h7042;
   localparam logic [15:0] IDX_IRQ_MASK = 16'h7043;
   localparam int ADR_W = 18;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int BIT_EVT_EN = 10;
   localparam int BIT_PIN_EN = 9;
   localparam int MSB_Q2 = 7;
   localparam int LSB_Q2 = 6;
   localparam int MSB_Q1 = 4;
   localparam int LSB_Q1 = 3;
   localparam int MSB_DIV = 2;
   localparam int BIT_C1_EN = 0;
   localparam int BIT_C2_EN = 1;
   localparam int BIT_SW_START = 2;
   localparam int RES_LSB = 6;
   localparam int IRQ_W = 4;
   localparam int IRQ_DONE1 = 0;
   localparam int IRQ_DONE2 = 1;
   localparam int IRQ_OVF1 = 2;
   localparam int IRQ_OVF2 = 3;

   // ****************************************
   // Values and timing
   // ****************************************
   localparam logic [15:0] RST_VAL = 16'h0000;
   localparam logic [1:0] Q_EMPTY = 2'h0;
   localparam logic [1:0] Q_ONE = 2'h1;
   localparam logic [1:0] Q_TWO = 2'h2;
   localparam logic [1:0] Q_OVF = 2'h3;
   // Converter clock periods per conversion (5.5 rounded up)
   localparam logic [3:0] CONV_TICKS = 4'h6;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONV = 2'b01,
      ST_DONE = 2'b10
   } atq_state_e;

   typedef struct packed {
      logic evt_en;
      logic pin_en;
      logic [2:0] div;
      logic c1_en;
      logic c2_en;
   } atq_cfg_s;

   typedef struct packed {
      logic [9:0] r1;
      logic [9:0] r2;
   } atq_res_s;

endpackage : atq_pkg

// [verilog/atq_top.sv]
`timescale 1ns/1ps
// Contract
// - Event starts only while bit 10 set
// - Pin rising edge starts while bit 9
// - Trigger and divider fields are shadowed
// - Shadowed writes apply from next conversion
// - Reserved control bits ignore writes
// - Bits 7-6 give second queue occupancy
// - Bits 4-3 give first queue occupancy
// - Two-deep queue, overflow drops oldest
// - Queue status live and read-only
// - Start sources ORed, coincident ones queued; only one start is held pending
// - Prescaler codes divide by 4..32
// - Result left-justified, low six zero
// - Results read-only, cleared by reset
// - Control and status fields reset zero
module atq_top
   import atq_pkg::*;
(
   input wire logic CLOCK, // System clock
   input wire logic SYS_RST, // Synchronous reset
   input wire logic [ADR_W-1:0] WB_ADR_I, // Byte address
   input wire logic [31:0] WB_DAT_I, // Write data
   input wire logic [3:0] WB_SEL_I, // Byte lanes
   input wire logic WB_WE_I, // Write
   input wire logic WB_CYC_I, // Cycle
   input wire logic WB_STB_I, // Strobe
   output logic [31:0] WB_DAT_O, // Read data
   output logic WB_ACK_O, // Acknowledge
   output logic WB_ERR_O, // Unmapped access
   input wire logic EVENT_START, // Event manager start pulse
   input wire logic EXTERNAL_TRIGGER_PIN, // Asynchronous trigger pin
   input wire logic CONV_RESULT_VALID, // Analog result ready
   input wire logic [9:0] CONV_RESULT1, // First converter value
   input wire logic [9:0] CONV_RESULT2, // Second converter value
   output logic CONV_CLOCK, // Divided converter clock
   output logic CONV_BUSY, // Conversion running
   output logic IRQ // Level interrupt
);

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [4:0] div_half(input logic [2:0] code);
      case (code)
         3'h0: div_half = 5'h02;
         3'h1: div_half = 5'h03;
         3'h2: div_half = 5'h04;
         3'h3: div_half = 5'h05;
         3'h4: div_half = 5'h06;
         3'h5: div_half = 5'h08;
         3'h6: div_half = 5'h0A;
         default: div_half = 5'h10;
      endcase
   endfunction : div_half

   function automatic logic [1:0] q_next(input logic [1:0] s,
         input logic push, input logic pop);
      logic [1:0] n;
      logic [1:0] cnt;
      n = s;
      cnt = (s == Q_OVF) ? Q_TWO : s;
      if (push && pop) begin
         n = (cnt == Q_EMPTY) ? Q_ONE : cnt;
      end else if (push) begin
         n = (cnt == Q_TWO) ? Q_OVF : cnt + 2'h1;
      end else if (pop) begin
         n = (cnt == Q_EMPTY) ? Q_EMPTY : cnt - 2'h1;
      end
      q_next = n;
   endfunction : q_next

   // Slot 0 is the oldest; a push on a full queue shifts it out
   function automatic logic [19:0] q_hold(input logic [1:0] s,
         input logic push, input logic pop, input logic [9:0] old0,
         input logic [9:0] old1, input logic [9:0] v);
      logic [1:0] cnt;
      logic [19:0] r;
      cnt = (s == Q_OVF) ? Q_TWO : s;
      r = {old1, old0};
      if (push && (cnt == Q_EMPTY || (cnt == Q_ONE && pop))) begin
         r[9:0] = v;
      end else if (push) begin
         r = {v, (pop || cnt == Q_TWO) ? old1 : old0};
      end else if (pop) begin
         r[9:0] = old1;
      end
      q_hold = r;
   endfunction : q_hold

   // ****************************************
   // Bus decode
   // ****************************************
   logic [15:0] idx;
   logic req, hit, wr, rd;
   logic ack_q, err_q;
   logic [31:0] dat_q;
   assign idx = WB_ADR_I[17:2];
   assign req = WB_CYC_I && WB_STB_I && !ack_q && !err_q;
   assign hit = idx == IDX_TRIG_CTRL || idx == IDX_FIRST_Q ||
      idx == IDX_SECOND_Q || idx == IDX_CONV_CTRL ||
      idx == IDX_CONV_DATA || idx == IDX_IRQ_STAT || idx == IDX_IRQ_MASK;
   assign wr = req && hit && WB_WE_I;
   assign rd = req && hit && !WB_WE_I;

   // ****************************************
   // Registers
   // ****************************************
   atq_cfg_s cfg_q, act_q;
   atq_state_e st_q;
   logic sw_start, evt_req, pin_req, pend_q;
   logic [1:0] s1_q, s2_q;
   atq_res_s h0_q, h1_q;
   logic [IRQ_W-1:0] ist_q, imsk_q;
   logic pop1, pop2, push1, push2;

   assign sw_start = wr && idx == IDX_CONV_CTRL && WB_SEL_I[0] &&
      WB_DAT_I[BIT_SW_START];

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         cfg_q <= '0;
      end else if (wr && idx == IDX_TRIG_CTRL) begin
         if (WB_SEL_I[1]) begin
            cfg_q.evt_en <= WB_DAT_I[BIT_EVT_EN];
            cfg_q.pin_en <= WB_DAT_I[BIT_PIN_EN];
         end
         if (WB_SEL_I[0]) begin
            cfg_q.div <= WB_DAT_I[MSB_DIV:0];
         end
      end else if (wr && idx == IDX_CONV_CTRL && WB_SEL_I[0]) begin
         cfg_q.c1_en <= WB_DAT_I[BIT_C1_EN];
         cfg_q.c2_en <= WB_DAT_I[BIT_C2_EN];
      end
   end

   // Working copy only loads while idle
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         act_q <= '0;
      end else if (st_q == ST_IDLE) begin
         act_q <= cfg_q;
      end
   end

   // ****************************************
   // Trigger inputs
   // ****************************************
   logic [2:0] pin_s_q;
   logic pin_lvl_q;
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         pin_s_q <= 3'h0;
         pin_lvl_q <= 1'b0;
      end else begin
         pin_s_q <= {pin_s_q[1:0], EXTERNAL_TRIGGER_PIN};
         if (pin_s_q[1] == pin_s_q[2]) begin
            pin_lvl_q <= pin_s_q[2];
         end
      end
   end
   assign pin_req = act_q.pin_en && pin_s_q[1] && pin_s_q[2] &&
      !pin_lvl_q;
   assign evt_req = act_q.evt_en && EVENT_START;

   // ****************************************
   // Converter clock and sequencing
   // ****************************************
   logic [4:0] div_cnt_q;
   logic [3:0] tick_q;
   logic cclk_q, tick_edge, any_en, start_any, multi_start;
   assign any_en = act_q.c1_en || act_q.c2_en;
   assign start_any = sw_start || evt_req || pin_req;
   // Two sources at once: run one, keep the other pending
   assign multi_start = (sw_start && (evt_req || pin_req)) ||
      (evt_req && pin_req) || (pend_q && start_any);
   assign tick_edge = div_cnt_q == 5'h01 && cclk_q;

   always_ff @(posedge CLOCK) begin
      if (SYS_RST || st_q != ST_CONV) begin
         div_cnt_q <= div_half(act_q.div);
         cclk_q <= 1'b0;
      end else if (div_cnt_q == 5'h01) begin
         div_cnt_q <= div_half(act_q.div);
         cclk_q <= !cclk_q;
      end else begin
         div_cnt_q <= div_cnt_q - 5'h01;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         st_q <= ST_IDLE;
         tick_q <= 4'h0;
         pend_q <= 1'b0;
      end else begin
         case (st_q)
            ST_IDLE: begin
               tick_q <= 4'h0;
               if (any_en && (pend_q || start_any)) begin
                  st_q <= ST_CONV;
                  pend_q <= multi_start;
               end
            end
            ST_CONV: begin
               if (start_any) begin
                  pend_q <= 1'b1;
               end
               if (tick_edge) begin
                  tick_q <= tick_q + 4'h1;
               end
               if (CONV_RESULT_VALID ||
                     (tick_edge && tick_q == CONV_TICKS - 4'h1)) begin
                  st_q <= ST_DONE;
               end
            end
            ST_DONE: begin
               if (start_any) begin
                  pend_q <= 1'b1;
               end
               st_q <= ST_IDLE;
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // Result queues
   // ****************************************
   assign push1 = st_q == ST_DONE && act_q.c1_en;
   assign push2 = st_q == ST_DONE && act_q.c2_en;
   assign pop1 = rd && idx == IDX_FIRST_Q && s1_q != Q_EMPTY;
   assign pop2 = rd && idx == IDX_SECOND_Q && s2_q != Q_EMPTY;

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         s1_q <= Q_EMPTY;
         s2_q <= Q_EMPTY;
      end else begin
         s1_q <= q_next(s1_q, push1, pop1);
         s2_q <= q_next(s2_q, push2, pop2);
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         h0_q <= '0;
         h1_q <= '0;
      end else begin
         {h1_q.r1, h0_q.r1} <= q_hold(s1_q, push1, pop1, h0_q.r1, h1_q.r1,
            CONV_RESULT1);
         {h1_q.r2, h0_q.r2} <= q_hold(s2_q, push2, pop2, h0_q.r2, h1_q.r2,
            CONV_RESULT2);
      end
   end

   // ****************************************
   // Interrupts
   // ****************************************
   logic [IRQ_W-1:0] ev;
   logic rd_ist;
   assign ev = {push2 && !pop2 && s2_q >= Q_TWO,
      push1 && !pop1 && s1_q >= Q_TWO, push2, push1};
   assign rd_ist = rd && idx == IDX_IRQ_STAT;
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         ist_q <= '0;
         imsk_q <= '0;
         IRQ <= 1'b0;
      end else begin
         ist_q <= (rd_ist ? '0 : ist_q) | ev;
         if (wr && idx == IDX_IRQ_MASK && WB_SEL_I[0]) begin
            imsk_q <= WB_DAT_I[IRQ_W-1:0];
         end
         IRQ <= |(ist_q & imsk_q);
      end
   end

   // ****************************************
   // Bus answer
   // ****************************************
   always_comb begin
      dat_q = '0;
      case (idx)
         IDX_TRIG_CTRL: begin
            dat_q[BIT_EVT_EN] = cfg_q.evt_en;
            dat_q[BIT_PIN_EN] = cfg_q.pin_en;
            dat_q[MSB_Q2:LSB_Q2] = s2_q;
            dat_q[MSB_Q1:LSB_Q1] = s1_q;
            dat_q[MSB_DIV:0] = cfg_q.div;
         end
         IDX_FIRST_Q: dat_q[15:RES_LSB] = h0_q.r1;
         IDX_SECOND_Q: dat_q[15:RES_LSB] = h0_q.r2;
         IDX_CONV_CTRL: dat_q[BIT_C2_EN:0] = {cfg_q.c2_en, cfg_q.c1_en};
         IDX_CONV_DATA: dat_q[0] = st_q != ST_IDLE;
         IDX_IRQ_STAT: dat_q[IRQ_W-1:0] = ist_q;
         IDX_IRQ_MASK: dat_q[IRQ_W-1:0] = imsk_q;
         default: dat_q = '0;
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         ack_q <= 1'b0;
         err_q <= 1'b0;
         WB_DAT_O <= '0;
         CONV_CLOCK <= 1'b0;
         CONV_BUSY <= 1'b0;
      end else begin
         ack_q <= req && hit;
         err_q <= req && !hit;
         WB_DAT_O <= rd ? dat_q : 32'h0000_0000;
         CONV_CLOCK <= cclk_q;
         CONV_BUSY <= st_q == ST_CONV;
      end
   end
   assign WB_ACK_O = ack_q;
   assign WB_ERR_O = err_q;

   // ****************************************
   // Checks
   // ****************************************
   chk_evt_masked: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      st_q == ST_IDLE && !act_q.evt_en && !pend_q && !sw_start && !pin_req
      |=> st_q == ST_IDLE) else $error("masked start began");
   chk_q_status: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      push1 && !pop1 && s1_q == Q_TWO |=> s1_q == Q_OVF)
      else $error("no overflow code");
   chk_pop_once: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      pop1 && !push1 && s1_q == Q_ONE |=> s1_q == Q_EMPTY)
      else $error("pop lost");
   chk_shadow_hold: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      st_q == ST_CONV |=> $stable(act_q)) else $error("shadow moved");
   chk_pend_run: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      st_q == ST_DONE && pend_q && any_en |=> ##1 st_q == ST_CONV)
      else $error("second start lost");
   chk_disabled: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      !any_en && st_q == ST_IDLE |=> st_q == ST_IDLE)
      else $error("disabled run");
   chk_res_low: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      $past(rd) && $past(idx) == IDX_FIRST_Q |-> WB_DAT_O[5:0] == 6'h00)
      else $error("low bits set");
   chk_ack_one: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
   cov_ovf: cover property (@(posedge CLOCK) s1_q == Q_OVF);
   cov_pend: cover property (@(posedge CLOCK) pend_q && st_q == ST_DONE);
   cov_pin: cover property (@(posedge CLOCK) pin_req);

endmodule : atq_top

// [sim/atq_analog_model.sv]
`timescale 1ns/1ps
module atq_analog_model
   import atq_pkg::*;
(
   input wire logic clk, // System clock
   input wire logic busy, // Conversion running
   input wire logic [7:0] lat, // Cycles to result, zero for never
   input wire logic [9:0] v1, // First value to deliver
   input wire logic [9:0] v2, // Second value to deliver
   output logic valid, // Result ready pulse
   output logic [9:0] r1, // First result
   output logic [9:0] r2 // Second result
);
   // ****
   // Result timing
   // ****
   logic [7:0] cnt_q = 8'h00;
   logic [2:0] hold_q = 3'h0;
   initial valid = 1'b0;
   always @(posedge clk) begin
      cnt_q <= busy ? cnt_q + 8'h01 : 8'h00;
      valid <= busy && lat != 8'h00 && cnt_q + 8'h01 == lat;
      hold_q <= busy ? 3'h3 : (hold_q != 3'h0 ? hold_q - 3'h1 : 3'h0);
   end
   // Past the hold window the lines no longer show the result
   assign r1 = (busy || hold_q != 3'h0) ? v1 : ~v1;
   assign r2 = (busy || hold_q != 3'h0) ? v2 : ~v2;
endmodule : atq_analog_model

// [sim/test_adc_trigger_and_result_queue.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
   n_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module test_adc_trigger_and_result_queue;
   import atq_pkg::*;
   // ****
   // Harness
   // ****
   logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic ev = 1'b0, pin = 1'b0, ok, bad, p;
   logic [ADR_W-1:0] adr = '0;
   logic [31:0] wdat = 32'h00000000, rdat;
   logic [3:0] sel = 4'h0;
   logic ack, err, vld, cclk, busy, irq;
   logic [9:0] v1 = 10'h000, v2 = 10'h000, r1, r2;
   logic [7:0] lat = 8'h04;
   logic [15:0] d, s;
   int n_errors = 0, n_compared = 0, cycles = 0, n, first;
   int divs[8] = '{4, 6, 8, 10, 12, 16, 20, 32};
   atq_top dut (.CLOCK(clk), .SYS_RST(rst), .WB_ADR_I(adr), .WB_DAT_I(wdat),
      .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_DAT_O(rdat), .WB_ACK_O(ack), .WB_ERR_O(err), .EVENT_START(ev),
      .EXTERNAL_TRIGGER_PIN(pin), .CONV_RESULT_VALID(vld),
      .CONV_RESULT1(r1), .CONV_RESULT2(r2), .CONV_CLOCK(cclk),
      .CONV_BUSY(busy), .IRQ(irq));
   atq_analog_model far (.clk(clk), .busy(busy), .lat(lat), .v1(v1),
      .v2(v2), .valid(vld), .r1(r1), .r2(r2));
   initial forever #2 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         conclude();
      end
   end
   task automatic conclude;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude
   task automatic wb(input logic w, input logic [15:0] i,
         input logic [15:0] v);
      adr <= {i, 2'b00};
      wdat <= {16'h0000, v};
      we <= w;
      sel <= 4'h3;
      cyc <= 1'b1;
      stb <= 1'b1;
      @(posedge clk);
      while (ack !== 1'b1 && err !== 1'b1) @(posedge clk);
      d = rdat[15:0];
      bad = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : wb
   task automatic wait_busy(input logic lvl, input int lim);
      ok = 1'b0;
      repeat (lim) begin
         @(posedge clk);
         if (busy === lvl) begin
            ok = 1'b1;
            break;
         end
      end
   endtask : wait_busy
   task automatic fire;
      ev <= 1'b1;
      @(posedge clk);
      ev <= 1'b0;
   endtask : fire
   task automatic conv(input logic [9:0] a, input logic [9:0] b);
      v1 <= a;
      v2 <= b;
      fire();
      wait_busy(1'b1, 8);
      `CHK("start", 1'b1, ok)
      wait_busy(1'b0, 400);
      repeat (3) @(posedge clk);
   endtask : conv
   // ****
   // Scenarios
   // ****
   task automatic t_regs;
      wb(0, IDX_TRIG_CTRL, 16'h0000);
      `CHK("ctrl_rst", 16'h0000, d)
      wb(0, IDX_FIRST_Q, 16'h0000);
      `CHK("res_rst", 16'h0000, d)
      wb(1, IDX_TRIG_CTRL, 16'hFFFF);
      wb(0, IDX_TRIG_CTRL, 16'h0000);
      `CHK("ctrl_rsv", 16'h0607, d)
      wb(1, IDX_SECOND_Q, 16'hFFFF);
      wb(0, IDX_SECOND_Q, 16'h0000);
      `CHK("res_ro", 16'h0000, d)
      wb(0, 16'h7035, 16'h0000);
      `CHK("unmapped", 1'b1, bad)
      wb(1, IDX_TRIG_CTRL, 16'h0000);
   endtask : t_regs
   task automatic t_event;
      wb(1, IDX_CONV_CTRL, 16'h0001);
      fire();
      wait_busy(1'b1, 12);
      `CHK("evt_masked", 1'b0, ok)
      wb(1, IDX_TRIG_CTRL, 16'h0400);
      conv(10'h3A5, 10'h111);
      wb(0, IDX_TRIG_CTRL, 16'h0000);
      `CHK("q1_one", Q_ONE, d[MSB_Q1:LSB_Q1])
      `CHK("q2_idle", Q_EMPTY, d[MSB_Q2:LSB_Q2])
      wb(0, IDX_FIRST_Q, 16'h0000);
      `CHK("res_just", {10'h3A5, 6'h00}, d)
      wb(0, IDX_TRIG_CTRL, 16'h0000);
      `CHK("q1_pop", Q_EMPTY, d[MSB_Q1:LSB_Q1])
   endtask : t_event
   task automatic t_ovf;
      wb(1, IDX_CONV_CTRL, 16'h0003);
      conv(10'h001, 10'h201);
      conv(10'h002, 10'h202);
      conv(10'h003, 10'h203);
      wb(0, IDX_TRIG_CTRL, 16'h0000);
      `CHK("q2_ovf", Q_OVF, d[MSB_Q2:LSB_Q2])
      `CHK("q1_ovf", Q_OVF, d[MSB_Q1:LSB_Q1])
      wb(0, IDX_FIRST_Q, 16'h0000);
      `CHK("drop_old", {10'h002, 6'h00}, d)
      wb(0, IDX_SECOND_Q, 16'h0000);
      `CHK("drop_old2", {10'h202, 6'h00}, d)
      wb(0, IDX_FIRST_Q, 16'h0000);
      `CHK("newest", {10'h003, 6'h00}, d)
      wb(0, IDX_SECOND_Q, 16'h0000);
      wb(0, IDX_TRIG_CTRL, 16'h0000);
      `CHK("drained", 16'h0400, d)
   endtask : t_ovf
   task automatic t_pin;
      wb(1, IDX_TRIG_CTRL, 16'h0200);
      pin <= 1'b1;
      wait_busy(1'b1, 12);
      `CHK("pin_start", 1'b1, ok)
      wait_busy(1'b0, 400);
      wait_busy(1'b1, 30);
      `CHK("pin_level", 1'b0, ok)
      pin <= 1'b0;
      fire();
      wait_busy(1'b1, 12);
      `CHK("evt_off", 1'b0, ok)
      wb(0, IDX_FIRST_Q, 16'h0000);
      wb(0, IDX_SECOND_Q, 16'h0000);
      wb(1, IDX_TRIG_CTRL, 16'h0600);
      pin <= 1'b1;
      fire();
      wait_busy(1'b1, 12);
      wait_busy(1'b0, 400);
      wait_busy(1'b1, 12);
      wait_busy(1'b0, 400);
      repeat (3) @(posedge clk);
      pin <= 1'b0;
      wb(0, IDX_TRIG_CTRL, 16'h0000);
      `CHK("two_conv", Q_TWO, d[MSB_Q1:LSB_Q1])
   endtask : t_pin
   task automatic t_presc;
      lat <= 8'h00;
      wb(1, IDX_CONV_CTRL, 16'h0001);
      wb(1, IDX_TRIG_CTRL, 16'h0400);
      for (int c = 0; c < 8; c++) begin
         fire();
         wait_busy(1'b1, 12);
         wb(1, IDX_TRIG_CTRL, 16'h0400 | 16'((c + 1) % 8));
         first = -1;
         n = 0;
         p = cclk;
         for (int k = 0; k < 200 && n == 0; k++) begin
            @(posedge clk);
            if (cclk === 1'b1 && p === 1'b0) begin
               if (first >= 0) n = k - first;
               first = k;
            end
            p = cclk;
         end
         `CHK("divide", divs[c], n)
         wait_busy(1'b0, 400);
      end
      lat <= 8'h04;
   endtask : t_presc
   task automatic t_off;
      wb(1, IDX_CONV_CTRL, 16'h0000);
      wb(0, IDX_TRIG_CTRL, 16'h0000);
      s = d;
      fire();
      wait_busy(1'b1, 12);
      `CHK("off_start", 1'b0, ok)
      wb(0, IDX_TRIG_CTRL, 16'h0000);
      `CHK("off_queue", s, d)
   endtask : t_off
   task automatic t_both;
      wb(1, IDX_CONV_CTRL, 16'h0001);
      wb(0, IDX_FIRST_Q, 16'h0000);
      wb(0, IDX_FIRST_Q, 16'h0000);
      fork
         wb(1, IDX_CONV_CTRL, 16'h0005);
         fire();
      join
      wb(0, IDX_CONV_DATA, 16'h0000);
      `CHK("busy_bit", 1'b1, d[0])
      repeat (60) @(posedge clk);
      wb(0, IDX_CONV_DATA, 16'h0000);
      `CHK("idle_bit", 1'b0, d[0])
      wb(0, IDX_TRIG_CTRL, 16'h0000);
      `CHK("both_two", Q_TWO, d[MSB_Q1:LSB_Q1])
   endtask : t_both
   task automatic t_rst;
      wb(1, IDX_TRIG_CTRL, 16'h0607);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      `CHK("irq_rst", 1'b0, irq)
      wb(0, IDX_TRIG_CTRL, 16'h0000);
      `CHK("ctrl_rst2", 16'h0000, d)
      wb(0, IDX_FIRST_Q, 16'h0000);
      `CHK("res_rst2", 16'h0000, d)
   endtask : t_rst
   task automatic t_irq;
      wb(1, IDX_CONV_CTRL, 16'h0001);
      wb(1, IDX_IRQ_MASK, 16'h0001);
      wb(0, IDX_IRQ_STAT, 16'h0000);
      repeat (2) @(posedge clk);
      `CHK("irq_clr", 1'b0, irq)
      conv(10'h155, 10'h0AA);
      `CHK("irq_set", 1'b1, irq)
      wb(0, IDX_IRQ_STAT, 16'h0000);
      `CHK("irq_done1", 1'b1, d[IRQ_DONE1])
      repeat (2) @(posedge clk);
      `CHK("irq_rc", 1'b0, irq)
      wb(1, IDX_IRQ_MASK, 16'h0000);
      conv(10'h156, 10'h0AB);
      `CHK("irq_mask", 1'b0, irq)
   endtask : t_irq
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_event();
      t_ovf();
      t_pin();
      t_presc();
      t_off();
      t_both();
      t_irq();
      t_rst();
      conclude();
   end
endmodule : test_adc_trigger_and_result_queue
